// *** rtl/kms_pkg.sv ***
// constants, types and register map of the key matrix scan control block
// assumes a 125 MHz clock and 16-bit registers at their printed addresses
package kms_pkg;

   // -------------------------------------------------
   // register addresses
   // -------------------------------------------------
   localparam logic [31:0] KMS_HALT_OFS   = 32'h0b00018c;
   localparam logic [31:0] KMS_STATE_OFS  = 32'h0b00018e;
   localparam logic [31:0] KMS_TIMING_OFS = 32'h0b000190;

   // -------------------------------------------------
   // fields and reset values
   // -------------------------------------------------
   localparam int          KMS_HALT_EN_BIT  = 0;
   localparam int          KMS_FIELD_W      = 5;
   localparam int          KMS_SETTLE_LSB   = 0;
   localparam int          KMS_RELEASE_LSB  = 5;
   localparam int          KMS_GAP_LSB      = 10;
   localparam logic [15:0] KMS_HALT_RST     = 16'h0000;
   localparam logic [15:0] KMS_TIMING_RST   = 16'h7fff;
   localparam logic [15:0] KMS_TIMING_MASK  = 16'h7fff;
   localparam int          KMS_GAP_W        = 10;

   // -------------------------------------------------
   // sequencer state codes as software sees them
   // -------------------------------------------------
   localparam logic [1:0]  KMS_CODE_SCAN    = 2'h3;
   localparam logic [1:0]  KMS_CODE_GAP     = 2'h2;
   localparam logic [1:0]  KMS_CODE_WAITKEY = 2'h1;
   localparam logic [1:0]  KMS_CODE_STOP    = 2'h0;

   // -------------------------------------------------
   // timing
   // -------------------------------------------------
   localparam int          KMS_TICK_US      = 30;
   localparam int          KMS_CLK_KHZ      = 125000;
   localparam int          KMS_TICK_CYCLES  = (KMS_TICK_US * KMS_CLK_KHZ) / 1000;
   localparam int          KMS_LINES        = 8;

   // -------------------------------------------------
   // types
   // -------------------------------------------------
   typedef enum logic [2:0] {
      KMS_ST_STOP    = 3'h0,
      KMS_ST_WAITKEY = 3'h1,
      KMS_ST_SETTLE  = 3'h3,
      KMS_ST_HOLD    = 3'h2,
      KMS_ST_IDLE    = 3'h6,
      KMS_ST_GAP     = 3'h7
   } kms_seq_type;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } kms_bus_req_type;

   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe;
   } kms_scan_pins_type;

endpackage

// *** rtl/kms_scan_ctrl.sv ***
// key matrix scan sequencer with dma page halt and pulse timing registers
// assumes one 125 MHz clock, return lines from pins, dma controller on the
// same clock, and start/auto-scan/gap settings from neighbouring registers
`timescale 1ns/1ns
`default_nettype none

module kms_scan_ctrl
   import kms_pkg::*;
#(
   parameter int TICK_CYCLES = KMS_TICK_CYCLES
) (
   // clock and reset
   input  wire  logic              ref_clk,
   input  wire  logic              nrst,
   // register port
   input  wire  kms_bus_req_type   bus,
   output logic [15:0]             rdata,
   // matrix pins
   output var   kms_scan_pins_type scan_line,
   input  wire  logic [7:0]        return_line,
   // neighbouring controls
   input  wire  logic              seq_enable,
   input  wire  logic              auto_scan_select,
   input  wire  logic [9:0]        set_gap_interval,
   input  wire  logic              unit_interrupt,
   // key data and dma
   output logic [63:0]             key_data,
   output logic                    key_data_valid,
   output logic                    dma_req,
   input  wire  logic              dma_ack,
   input  wire  logic              dma_page_boundary,
   output logic                    dma_halted,
   output logic                    data_lost_interrupt
);

   // -------------------------------------------------
   // reset release and pin synchronisers
   // -------------------------------------------------
   logic       rst_meta_reg;
   logic       rst_n;
   logic [7:0] ret_meta_reg;
   logic [7:0] ret_sync_reg;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ret_meta_reg <= 8'h00;
         ret_sync_reg <= 8'h00;
      end else begin
         ret_meta_reg <= return_line;
         ret_sync_reg <= ret_meta_reg;
      end
   end

   // -------------------------------------------------
   // registers
   // -------------------------------------------------
   logic        halt_en_reg;
   logic [15:0] timing_reg;
   logic [1:0]  state_code;
   logic        hit_halt;
   logic        hit_state;
   logic        hit_timing;
   logic [15:0] rd_mux;

   assign hit_halt   = (bus.addr == KMS_HALT_OFS);
   assign hit_state  = (bus.addr == KMS_STATE_OFS);
   assign hit_timing = (bus.addr == KMS_TIMING_OFS);

   // reserved bits and unmapped addresses read zero
   assign rd_mux = hit_halt   ? {15'h0000, halt_en_reg} :
                   hit_state  ? {14'h0000, state_code}  :
                   hit_timing ? (timing_reg & KMS_TIMING_MASK) :
                                16'h0000;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         halt_en_reg <= KMS_HALT_RST[KMS_HALT_EN_BIT];
         timing_reg  <= KMS_TIMING_RST;
         rdata       <= 16'h0000;
      end else begin
         if (bus.wr && hit_halt) begin
            halt_en_reg <= bus.wdata[KMS_HALT_EN_BIT];
         end
         if (bus.wr && hit_timing) begin
            timing_reg <= bus.wdata & KMS_TIMING_MASK;
         end
         rdata <= bus.rd ? rd_mux : 16'h0000;
      end
   end

   // -------------------------------------------------
   // timing fields
   // -------------------------------------------------
   logic [4:0] settle_time_count;
   logic [4:0] release_time_count;
   logic [4:0] gap_time_count;

   assign settle_time_count  = timing_reg[KMS_SETTLE_LSB  +: KMS_FIELD_W];
   assign release_time_count = timing_reg[KMS_RELEASE_LSB +: KMS_FIELD_W];
   assign gap_time_count     = timing_reg[KMS_GAP_LSB     +: KMS_FIELD_W];

   // -------------------------------------------------
   // 30 us tick, restarted on every phase change
   // -------------------------------------------------
   // restarting keeps the first tick of a phase a full 30 us long
   logic [11:0] presc_reg;
   logic        tick;
   logic        phase_start;

   assign tick = (presc_reg == 12'(TICK_CYCLES - 1));

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         presc_reg <= 12'h000;
      end else if (phase_start || tick) begin
         presc_reg <= 12'h000;
      end else begin
         presc_reg <= presc_reg + 12'h001;
      end
   end

   // -------------------------------------------------
   // phase counter
   // -------------------------------------------------
   kms_seq_type state_reg;
   kms_seq_type state_next;
   logic [9:0]  cnt_reg;
   logic [9:0]  target;
   logic        phase_done;
   logic [2:0]  line_reg;
   logic [2:0]  line_next;
   logic        last_line;
   logic        gap_zero;

   assign last_line   = (line_reg == 3'h7);
   assign gap_zero    = (set_gap_interval == 10'h000);
   assign phase_start = (state_next != state_reg) ||
                        (state_next == KMS_ST_SETTLE && line_next != line_reg);

   // phase lasts target+1 ticks; gap lasts exactly set_gap_interval ticks
   assign target = (state_reg == KMS_ST_SETTLE) ? {5'h00, settle_time_count}  :
                   (state_reg == KMS_ST_HOLD)   ? {5'h00, release_time_count} :
                   (state_reg == KMS_ST_IDLE)   ? {5'h00, gap_time_count}     :
                                                  (set_gap_interval - 10'h001);
   assign phase_done = tick && (cnt_reg == target);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 10'h000;
      end else if (phase_start) begin
         cnt_reg <= 10'h000;
      end else if (tick) begin
         cnt_reg <= cnt_reg + 10'h001;
      end
   end

   // -------------------------------------------------
   // scan sequencer
   // -------------------------------------------------
   logic any_key;
   logic sample;
   logic set_done;

   assign any_key  = |ret_sync_reg;
   assign sample   = (state_reg == KMS_ST_SETTLE) && phase_done;
   assign set_done = sample && last_line;

   always_comb begin
      state_next = state_reg;
      line_next  = line_reg;
      case (state_reg)
         KMS_ST_STOP: begin
            line_next = 3'h0;
            if (seq_enable) begin
               state_next = auto_scan_select ? KMS_ST_WAITKEY
                                             : KMS_ST_SETTLE;
            end
         end
         KMS_ST_WAITKEY: begin
            if (!seq_enable) begin
               state_next = KMS_ST_STOP;
            end else if (any_key) begin
               state_next = KMS_ST_SETTLE;
            end
         end
         KMS_ST_SETTLE: begin
            if (phase_done) begin
               state_next = KMS_ST_HOLD;
            end
         end
         KMS_ST_HOLD: begin
            if (phase_done) begin
               state_next = KMS_ST_IDLE;
            end
         end
         KMS_ST_IDLE: begin
            if (phase_done) begin
               if (!last_line) begin
                  state_next = KMS_ST_SETTLE;
                  line_next  = line_reg + 3'h1;
               end else if (!seq_enable) begin
                  state_next = KMS_ST_STOP;
               end else if (!gap_zero) begin
                  state_next = KMS_ST_GAP;
               end else begin
                  state_next = KMS_ST_SETTLE;
                  line_next  = 3'h0;
               end
            end
         end
         KMS_ST_GAP: begin
            if (!seq_enable) begin
               state_next = KMS_ST_STOP;
            end else if (phase_done) begin
               state_next = KMS_ST_SETTLE;
               line_next  = 3'h0;
            end
         end
         default: begin
            state_next = KMS_ST_STOP;
            line_next  = 3'h0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= KMS_ST_STOP;
         line_reg  <= 3'h0;
      end else begin
         state_reg <= state_next;
         line_reg  <= line_next;
      end
   end

   // -------------------------------------------------
   // state code, last idle of a set already counts as gap
   // -------------------------------------------------
   logic in_gap;

   assign in_gap = (state_reg == KMS_ST_GAP) ||
                   (state_reg == KMS_ST_IDLE && last_line);
   assign state_code = (state_reg == KMS_ST_STOP)    ? KMS_CODE_STOP    :
                       (state_reg == KMS_ST_WAITKEY) ? KMS_CODE_WAITKEY :
                       in_gap                        ? KMS_CODE_GAP     :
                                                       KMS_CODE_SCAN;

   // -------------------------------------------------
   // scan line drive
   // -------------------------------------------------
   logic [7:0] drive_next;

   always_comb begin
      drive_next = 8'h00;
      if (state_reg == KMS_ST_WAITKEY) begin
         drive_next = 8'hff;
      end else if (state_reg == KMS_ST_SETTLE || state_reg == KMS_ST_HOLD) begin
         drive_next = 8'h01 << line_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scan_line <= '0;
      end else begin
         scan_line.level <= drive_next;
         scan_line.oe    <= drive_next;
      end
   end

   // -------------------------------------------------
   // key data capture
   // -------------------------------------------------
   logic [63:0] set_reg;
   logic [63:0] set_next;

   genvar gi;
   generate
      for (gi = 0; gi < KMS_LINES; gi = gi + 1) begin : g_cap
         assign set_next[gi*8 +: 8] = (sample && line_reg == 3'(gi)) ?
                                      ret_sync_reg : set_reg[gi*8 +: 8];
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         set_reg        <= 64'h0;
         key_data       <= 64'h0;
         key_data_valid <= 1'b0;
      end else begin
         set_reg        <= set_next;
         key_data_valid <= set_done;
         if (set_done) begin
            key_data <= set_next;
         end
      end
   end

   // -------------------------------------------------
   // dma request and page halt
   // -------------------------------------------------
   // scanning never waits for dma, so an unserved set is overwritten
   logic pend_reg;
   logic halt_reg;
   logic intr_d_reg;
   logic intr_cleared;

   assign intr_cleared = intr_d_reg && !unit_interrupt;
   assign dma_req      = pend_reg && !halt_reg;
   assign dma_halted   = halt_reg;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg            <= 1'b0;
         halt_reg            <= 1'b0;
         intr_d_reg          <= 1'b0;
         data_lost_interrupt <= 1'b0;
      end else begin
         intr_d_reg <= unit_interrupt;
         if (key_data_valid) begin
            pend_reg <= 1'b1;
         end else if (dma_ack && dma_req) begin
            pend_reg <= 1'b0;
         end
         data_lost_interrupt <= key_data_valid && pend_reg &&
                                !(dma_ack && dma_req);
         if (dma_page_boundary && halt_en_reg) begin
            halt_reg <= 1'b1;
         end else if (!halt_en_reg || intr_cleared) begin
            halt_reg <= 1'b0;
         end
      end
   end

endmodule // kms_scan_ctrl

`default_nettype wire

// *** tb/kms_scan_ctrl_properties.sv ***
// concurrent checks on the ports of the key matrix scan control block
// assumes it is bound to kms_scan_ctrl and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
module kms_scan_ctrl_checker
   import kms_pkg::*;
#(
   parameter int TICK_CYCLES = KMS_TICK_CYCLES
) (
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              nrst,
   // register port
   input wire kms_bus_req_type   bus,
   input wire logic [15:0]       rdata,
   // matrix pins
   input wire kms_scan_pins_type scan_line,
   // key data and dma
   input wire logic              key_data_valid,
   input wire logic              dma_req,
   input wire logic              dma_ack,
   input wire logic              dma_page_boundary,
   input wire logic              dma_halted,
   input wire logic              data_lost_interrupt
);
   // -------------------------------------------------
   // helper logic
   // -------------------------------------------------
   logic [7:0] last_oe_reg;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         last_oe_reg <= 8'h00;
      end else if ($onehot(scan_line.oe)) begin
         last_oe_reg <= scan_line.oe;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // -------------------------------------------------
   // assertions
   // -------------------------------------------------
   sequence s_state_read;
      $past(bus.rd) && $past(bus.addr) == KMS_STATE_OFS;
   endsequence
   sequence s_ack_taken;
      dma_req && dma_ack && !key_data_valid;
   endsequence

   chk_rdata_quiet: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
      else $error("read data not zero outside a read answer");
   chk_state_reserved: assert property (s_state_read |-> rdata[15:2] == 14'h0000)
      else $error("state register reserved bits not zero");
   chk_waitkey_high: assert property (
      s_state_read and rdata[1:0] == KMS_CODE_WAITKEY |-> scan_line.oe == 8'hff)
      else $error("wait-key state without all scan lines high");
   chk_halt_no_req: assert property (dma_halted |-> !dma_req)
      else $error("dma request while halted");
   chk_halt_cause: assert property ($rose(dma_halted) |-> $past(dma_page_boundary))
      else $error("halt without page boundary");
   chk_req_follows: assert property (
      key_data_valid && !dma_halted && !dma_page_boundary && !dma_ack |=> dma_req)
      else $error("no dma request after new key data");
   chk_ack_clears: assert property (s_ack_taken |=> !dma_req)
      else $error("dma request stays after acknowledge");
   chk_lost_flag: assert property (key_data_valid && dma_req && !dma_ack |=> data_lost_interrupt)
      else $error("overwritten set without data lost pulse");
   chk_level_oe: assert property (scan_line.level == scan_line.oe)
      else $error("scan line driven low or level without enable");
   chk_one_line: assert property ($onehot0(scan_line.oe) || scan_line.oe == 8'hff)
      else $error("more than one scan line driven");
   chk_line_order: assert property (
      $onehot(scan_line.oe) && $past(scan_line.oe) == 8'h00
      |-> scan_line.oe == 8'h01 || scan_line.oe == (last_oe_reg << 1))
      else $error("scan lines out of ascending order");
endmodule // kms_scan_ctrl_checker
`default_nettype wire

// *** tb/kms_key_matrix.sv ***
// key switch matrix model between scan lines and return lines
// assumes return lines carry pull-downs, so an open key reads low
`timescale 1ns/1ns
`default_nettype none
module kms_key_matrix
   import kms_pkg::*;
(
   // scan side
   input  wire kms_scan_pins_type scan_line,
   // closed keys, bit 8k+j joins scan line k to return line j
   input  wire logic [63:0]       keys,
   // return side
   output logic [7:0]             return_line
);
   // released lines carry nothing, so the pull-downs win
   always_comb begin
      return_line = 8'h00;
      for (int k = 0; k < KMS_LINES; k++) begin
         if (scan_line.oe[k] && scan_line.level[k]) begin
            return_line = return_line | keys[8*k +: 8];
         end
      end
   end
endmodule // kms_key_matrix
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the key matrix scan control block
// assumes the checker and the key matrix model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module testbench
   import kms_pkg::*;
;
   localparam int          TICK = 4;
   localparam logic [63:0] KEYS = 64'h0001_0000_2000_0000;
   logic              ref_clk, nrst, seq_enable, auto_scan_select, unit_interrupt;
   logic              dma_ack, dma_page_boundary, key_data_valid, dma_req;
   logic              dma_halted, data_lost_interrupt;
   logic [9:0]        set_gap_interval;
   logic [63:0]       keys, key_data;
   logic [15:0]       rdata, v;
   logic [7:0]        return_line;
   kms_bus_req_type   bus;
   kms_scan_pins_type scan_line;
   int                bad_count, cmp_count, n;

   kms_scan_ctrl #(.TICK_CYCLES(TICK)) i_kms_scan_ctrl (.ref_clk, .nrst, .bus, .rdata,
      .scan_line, .return_line, .seq_enable, .auto_scan_select, .set_gap_interval,
      .unit_interrupt, .key_data, .key_data_valid, .dma_req, .dma_ack, .dma_page_boundary,
      .dma_halted, .data_lost_interrupt);
   kms_key_matrix i_kms_key_matrix (.scan_line, .keys, .return_line);

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // -------------------------------------------------
   // tasks
   // -------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge ref_clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk) bus <= '0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [15:0] d);
      @(posedge ref_clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge ref_clk) bus <= '0;
      #1 d = rdata;
   endtask
   task automatic rdc(input logic [31:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk(d, e);
   endtask
   task automatic wait_oe(input logic [7:0] e);
      for (int i = 0; i < 500 && scan_line.oe !== e; i++) @(negedge ref_clk);
      chk(scan_line.oe, e);
   endtask
   // cycles the scan pins keep one pattern, sampled mid-cycle
   task automatic count_oe(input logic [7:0] e, output int c);
      c = 0;
      while (scan_line.oe === e && c < 1000) begin
         c++;
         @(negedge ref_clk);
      end
   endtask
   task automatic wait_valid;
      for (int i = 0; i < 1000 && key_data_valid !== 1'b1; i++) @(negedge ref_clk);
      chk(key_data_valid, 1'b1);
   endtask
   task automatic ack;
      @(posedge ref_clk) dma_ack <= 1'b1;
      @(posedge ref_clk) dma_ack <= 1'b0;
      @(negedge ref_clk) chk(dma_req, 1'b0);
   endtask
   task automatic bnd;
      @(posedge ref_clk) dma_page_boundary <= 1'b1;
      @(posedge ref_clk) dma_page_boundary <= 1'b0;
      @(negedge ref_clk) chk(dma_halted, 1'b1);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // -------------------------------------------------
   // tests
   // -------------------------------------------------
   initial begin
      nrst = 1'b0;
      bus = '0;
      seq_enable = 1'b0;
      auto_scan_select = 1'b0;
      unit_interrupt = 1'b0;
      dma_ack = 1'b0;
      dma_page_boundary = 1'b0;
      set_gap_interval = 10'h005;
      keys = 64'h0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdc(KMS_HALT_OFS, KMS_HALT_RST);
      rdc(KMS_TIMING_OFS, KMS_TIMING_RST);
      rdc(KMS_STATE_OFS, {14'h0, KMS_CODE_STOP});
      rdc(32'h0b00018d, 16'h0000);
      wr(KMS_TIMING_OFS, 16'hffff);
      rdc(KMS_TIMING_OFS, KMS_TIMING_MASK);
      wr(KMS_HALT_OFS, 16'hffff);
      rdc(KMS_HALT_OFS, 16'h0001);
      wr(KMS_STATE_OFS, 16'h0003);
      rdc(KMS_STATE_OFS, 16'h0000);
      wr(KMS_HALT_OFS, 16'h0000);
      // settle 1, hold 2, idle 3
      wr(KMS_TIMING_OFS, 16'h0c41);
      rdc(KMS_TIMING_OFS, 16'h0c41);
      @(posedge ref_clk);
      auto_scan_select <= 1'b1;
      seq_enable <= 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(scan_line.oe, 8'hff);
      rdc(KMS_STATE_OFS, {14'h0, KMS_CODE_WAITKEY});
      @(posedge ref_clk);
      keys <= KEYS;
      wait_oe(8'h01);
      count_oe(8'h01, n);
      chk(n >= 5 * TICK && n <= 5 * TICK + 2, 1'b1);
      count_oe(8'h00, n);
      chk(n >= 4 * TICK && n <= 4 * TICK + 2, 1'b1);
      chk(scan_line.oe, 8'h02);
      rdc(KMS_STATE_OFS, {14'h0, KMS_CODE_SCAN});
      wait_valid;
      chk(key_data, KEYS);
      @(negedge ref_clk);
      chk(dma_req, 1'b1);
      wait_oe(8'h00);
      count_oe(8'h00, n);
      chk(n >= 9 * TICK && n <= 9 * TICK + 2, 1'b1);
      wait_valid;
      @(negedge ref_clk);
      chk(data_lost_interrupt, 1'b1);
      ack;
      wait_oe(8'h00);
      rdc(KMS_STATE_OFS, {14'h0, KMS_CODE_GAP});
      wr(KMS_HALT_OFS, 16'h0001);
      bnd;
      wait_valid;
      @(negedge ref_clk);
      chk(dma_req, 1'b0);
      wr(KMS_HALT_OFS, 16'h0000);
      repeat (2) @(negedge ref_clk);
      chk(dma_halted, 1'b0);
      chk(dma_req, 1'b1);
      ack;
      wr(KMS_HALT_OFS, 16'h0001);
      bnd;
      @(posedge ref_clk) unit_interrupt <= 1'b1;
      @(posedge ref_clk) unit_interrupt <= 1'b0;
      repeat (3) @(negedge ref_clk);
      chk(dma_halted, 1'b0);
      @(posedge ref_clk) seq_enable <= 1'b0;
      v = 16'hffff;
      // a set in progress finishes before the stop shows
      for (int i = 0; i < 300 && v !== 16'h0000; i++) rd(KMS_STATE_OFS, v);
      chk(v, {14'h0, KMS_CODE_STOP});
      // without auto scan the first line comes up with no key wait
      @(posedge ref_clk) auto_scan_select <= 1'b0;
      seq_enable <= 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(scan_line.oe, 8'h01);
      // reinitialise in mid-scan, as software must after lost data
      @(posedge ref_clk) nrst <= 1'b0;
      seq_enable <= 1'b0;
      @(negedge ref_clk);
      chk(scan_line.oe, 8'h00);
      @(posedge ref_clk) nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdc(KMS_TIMING_OFS, KMS_TIMING_RST);
      rdc(KMS_STATE_OFS, {14'h0, KMS_CODE_STOP});
      results;
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      results;
   end
endmodule // testbench

bind kms_scan_ctrl kms_scan_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) i_kms_scan_ctrl_checker (
   .ref_clk, .nrst, .bus, .rdata, .scan_line, .key_data_valid, .dma_req, .dma_ack,
   .dma_page_boundary, .dma_halted, .data_lost_interrupt);
`default_nettype wire
